// ---- rtl/csp_params.svh ----
`ifndef CSP_PARAMS_SVH
`define CSP_PARAMS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CSP_CLK_HZ 200000000
`define CSP_POLL_S 30
`define CSP_RSP_S 5
`define CSP_TMR_W 33

// ------------------------------------------------------------
// File system layout
// ------------------------------------------------------------
`define CSP_DIR_FID 16'h7F90
`define CSP_EF_HI 8'h6F
`define CSP_NFILE 16
`define CSP_NWORD 16
`define CSP_LP_IDX 4'h0
`define CSP_IDENT_IDX 4'h4
`define CSP_LOC_IDX 4'h8
`define CSP_ALGO_IDX 4'hC
`define CSP_FREE_LAST 4'h3
`define CSP_MEM_RST 8'hFF

// ------------------------------------------------------------
// Procedure constants
// ------------------------------------------------------------
`define CSP_LANG_NONE 8'hFF
`define CSP_LANG_DEFAULT 8'h01
`define CSP_INIT_LAST 5'h1A
`define CSP_TRIES_MAX 2'h2

`endif

// ---- rtl/csp_pkg.sv ----
package csp_pkg;

	typedef enum logic [2:0] {
		OP_SELECT = 3'h0,
		OP_READ = 3'h1,
		OP_UPDATE = 3'h2,
		OP_INVAL = 3'h3,
		OP_STATUS = 3'h4,
		OP_VERIFY = 3'h5,
		OP_ALGO = 3'h6
	} csp_op_type;

	typedef enum logic [1:0] {
		SW_OK = 2'h0,
		SW_DENIED = 2'h1,
		SW_NOFILE = 2'h2,
		SW_BLOCKED = 2'h3
	} csp_sw_type;

	typedef enum logic [1:0] {
		ST_OFF = 2'h0,
		ST_SEND = 2'h1,
		ST_WAIT = 2'h2,
		ST_SESS = 2'h3
	} csp_state_type;

	typedef enum logic [1:0] {
		JB_INIT = 2'h0,
		JB_USR = 2'h1,
		JB_POLL = 2'h2,
		JB_TERM = 2'h3
	} csp_job_type;

endpackage

// ---- rtl/csp_link_if.sv ----
// Command/response link; the terminal end is master of every pair.
interface csp_link_if;
	logic link_up;
	logic cmd_valid;
	csp_pkg::csp_op_type cmd_op;
	logic [15:0] cmd_fid;
	logic [7:0] cmd_ofs;
	logic [7:0] cmd_data;
	logic rsp_valid;
	csp_pkg::csp_sw_type rsp_sw;
	logic [15:0] rsp_data;

	modport card (
		input link_up, cmd_valid, cmd_op, cmd_fid, cmd_ofs, cmd_data,
		output rsp_valid, rsp_sw, rsp_data
	);
	modport term (
		output link_up, cmd_valid, cmd_op, cmd_fid, cmd_ofs, cmd_data,
		input rsp_valid, rsp_sw, rsp_data
	);
endinterface

// ---- rtl/csp_card.sv ----
`include "csp_params.svh"

module csp_card #(
	parameter logic [15:0] HOLDER_CODE = 16'h1234
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	csp_link_if.card lnk,
	output logic code_blocked_o,
	output logic access_granted_o,
	output logic [15:0] cur_dir_o
);

	localparam int NF = `CSP_NFILE;
	localparam int NW = `CSP_NWORD;

	logic [7:0] mem_ff [NF][NW];
	logic [NF-1:0] inval_ff;
	logic [15:0] cur_dir_ff;
	logic [3:0] cur_ef_ff;
	logic ef_sel_ff;
	logic granted_ff;
	logic blocked_ff;
	logic [1:0] tries_ff;
	logic rsp_valid_ff;
	csp_pkg::csp_sw_type rsp_sw_ff;
	logic [15:0] rsp_data_ff;

	logic [3:0] idx;
	logic [3:0] wofs;
	logic ef_fid;
	logic dir_ok;
	logic rd_ok;
	logic wr_ok;
	logic inv_ok;
	logic algo_ok;
	logic code_ok;

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------
	// Every decision is made from the command and current state only.
	assign idx = lnk.cmd_fid[3:0];
	assign wofs = lnk.cmd_ofs[3:0];
	assign ef_fid = (lnk.cmd_fid[15:8] == `CSP_EF_HI) &&
		(lnk.cmd_fid[7:4] == 4'h0);
	assign dir_ok = (cur_dir_ff == `CSP_DIR_FID);
	assign rd_ok = ef_sel_ff && !inval_ff[cur_ef_ff] &&
		((cur_ef_ff <= `CSP_FREE_LAST) || granted_ff);
	assign wr_ok = ef_sel_ff && !inval_ff[cur_ef_ff] && granted_ff;
	assign inv_ok = ef_sel_ff && granted_ff &&
		(cur_ef_ff != `CSP_IDENT_IDX);
	assign algo_ok = dir_ok && granted_ff;
	assign code_ok = (lnk.cmd_fid == HOLDER_CODE);

	assign lnk.rsp_valid = rsp_valid_ff;
	assign lnk.rsp_sw = rsp_sw_ff;
	assign lnk.rsp_data = rsp_data_ff;
	assign code_blocked_o = blocked_ff;
	assign access_granted_o = granted_ff;
	assign cur_dir_o = cur_dir_ff;

	// ------------------------------------------------------------
	// Responses
	// ------------------------------------------------------------
	// The card never speaks first: a response only follows a command.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rsp_valid_ff <= 1'b0;
			rsp_sw_ff <= csp_pkg::SW_OK;
			rsp_data_ff <= 16'h0000;
		end else begin
			rsp_valid_ff <= lnk.cmd_valid && lnk.link_up;
			if (lnk.cmd_valid && lnk.link_up) begin
				rsp_sw_ff <= csp_pkg::SW_OK;
				rsp_data_ff <= 16'h0000;
				case (lnk.cmd_op)
					csp_pkg::OP_SELECT: begin
						if (lnk.cmd_fid == `CSP_DIR_FID)
							rsp_data_ff <= `CSP_DIR_FID;
						else if (ef_fid)
							rsp_data_ff <= {15'h0000, inval_ff[idx]};
						else
							rsp_sw_ff <= csp_pkg::SW_NOFILE;
					end
					csp_pkg::OP_READ: begin
						if (rd_ok)
							rsp_data_ff <= {8'h00, mem_ff[cur_ef_ff][wofs]};
						else
							rsp_sw_ff <= csp_pkg::SW_DENIED;
					end
					csp_pkg::OP_UPDATE: begin
						if (!wr_ok)
							rsp_sw_ff <= csp_pkg::SW_DENIED;
					end
					csp_pkg::OP_INVAL: begin
						if (!inv_ok)
							rsp_sw_ff <= csp_pkg::SW_DENIED;
					end
					csp_pkg::OP_STATUS: rsp_data_ff <= cur_dir_ff;
					csp_pkg::OP_VERIFY: begin
						if (blocked_ff)
							rsp_sw_ff <= csp_pkg::SW_BLOCKED;
						else if (!code_ok)
							rsp_sw_ff <= (tries_ff == `CSP_TRIES_MAX) ?
								csp_pkg::SW_BLOCKED : csp_pkg::SW_DENIED;
					end
					csp_pkg::OP_ALGO: begin
						if (!algo_ok)
							rsp_sw_ff <= csp_pkg::SW_DENIED;
					end
					default: rsp_sw_ff <= csp_pkg::SW_NOFILE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// File contents
	// ------------------------------------------------------------
	// Erased cells read as all ones, which also means no language set.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int f = 0; f < NF; f++) begin
				for (int w = 0; w < NW; w++) begin
					mem_ff[f][w] <= `CSP_MEM_RST;
				end
			end
		end else if (lnk.cmd_valid && lnk.link_up) begin
			if (lnk.cmd_op == csp_pkg::OP_UPDATE && wr_ok)
				mem_ff[cur_ef_ff][wofs] <= lnk.cmd_data;
			else if (lnk.cmd_op == csp_pkg::OP_ALGO && algo_ok)
				mem_ff[`CSP_ALGO_IDX][0] <= 8'(mem_ff[`CSP_ALGO_IDX][0] +
					lnk.cmd_data);
		end
	end

	// Invalidation survives the end of a session, like the data.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			inval_ff <= '0;
		end else if (lnk.cmd_valid && lnk.link_up &&
			lnk.cmd_op == csp_pkg::OP_INVAL && inv_ok) begin
			inval_ff[cur_ef_ff] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Selection
	// ------------------------------------------------------------
	// Losing the link ends the session, so the selection is dropped.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cur_dir_ff <= 16'h0000;
			cur_ef_ff <= 4'h0;
			ef_sel_ff <= 1'b0;
		end else if (!lnk.link_up) begin
			cur_dir_ff <= 16'h0000;
			ef_sel_ff <= 1'b0;
		end else if (lnk.cmd_valid && lnk.cmd_op == csp_pkg::OP_SELECT) begin
			if (lnk.cmd_fid == `CSP_DIR_FID) begin
				cur_dir_ff <= `CSP_DIR_FID;
				ef_sel_ff <= 1'b0;
			end else if (ef_fid) begin
				cur_ef_ff <= idx;
				ef_sel_ff <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Holder code
	// ------------------------------------------------------------
	// The wrong-try count is not cleared by a new session on purpose.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			granted_ff <= 1'b0;
			blocked_ff <= 1'b0;
			tries_ff <= 2'h0;
		end else if (!lnk.link_up) begin
			granted_ff <= 1'b0;
		end else if (lnk.cmd_valid && lnk.cmd_op == csp_pkg::OP_VERIFY &&
			!blocked_ff) begin
			if (code_ok) begin
				granted_ff <= 1'b1;
				tries_ff <= 2'h0;
			end else if (tries_ff == `CSP_TRIES_MAX) begin
				blocked_ff <= 1'b1;
				granted_ff <= 1'b0;
			end else begin
				tries_ff <= 2'(tries_ff + 2'h1);
			end
		end
	end

endmodule

// ---- rtl/csp_term.sv ----
// Summary of operation
// - terminal originates commands, card only answers.
// - select file first; command carries data location.
// - permitted read returns file data.
// - refused read returns error, no data.
// - permitted update overwrites addressed file content.
// - refused update leaves file, returns error.
// - invalidate only when its access allowed.
// - card algorithm may change file contents.
// - interrupted procedure is aborted as whole.
// - session spans initialization to termination/link loss.
// - language request, default when none available.
// - select app directory, check identity invalidation.
// - holder code verify; failure fails initialization.
// - eleven information requests in fixed order.
// - write back, then deactivate link, erase copy.
// - unchanged already-written item may skip write-back.
// - status command within each 30 s idle.
// - no status answer: drop call within 5 s.
// - changed directory in status: drop call.
// - application directory identifier is 7F90.
// - third wrong code blocks and withdraws access.
`include "csp_params.svh"

module csp_term #(
	parameter longint unsigned POLL_CYC = 64'(`CSP_POLL_S) * 64'(`CSP_CLK_HZ),
	parameter longint unsigned RSP_CYC = 64'(`CSP_RSP_S) * 64'(`CSP_CLK_HZ)
) (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	csp_link_if.term lnk,
	input wire logic sess_start_i,
	input wire logic sess_end_i,
	input wire logic call_active_i,
	input wire logic [15:0] code_i,
	input wire logic usr_valid_i,
	input wire logic usr_write_i,
	input wire logic [15:0] usr_fid_i,
	input wire logic [7:0] usr_ofs_i,
	input wire logic [7:0] usr_data_i,
	input wire logic loc_we_i,
	input wire logic [7:0] loc_i,
	output logic usr_ready_o,
	output logic usr_done_o,
	output logic usr_ok_o,
	output logic [7:0] usr_data_o,
	output logic sess_active_o,
	output logic init_fail_o,
	output logic ident_invalid_o,
	output logic call_drop_o,
	output logic [7:0] lang_o,
	output logic [7:0] loc_o
);

	localparam logic [`CSP_TMR_W-1:0] POLL_LAST =
		`CSP_TMR_W'(POLL_CYC - 64'h1);
	localparam logic [`CSP_TMR_W-1:0] RSP_LAST =
		`CSP_TMR_W'(RSP_CYC - 64'h1);

	csp_pkg::csp_state_type state_ff;
	csp_pkg::csp_job_type job_ff;
	logic [4:0] step_ff;
	logic link_up_ff;
	csp_pkg::csp_op_type op_ff;
	logic [15:0] fid_ff;
	logic [7:0] ofs_ff;
	logic [7:0] dat_ff;
	logic [`CSP_TMR_W-1:0] tmr_ff;
	logic [7:0] loc_ff;
	logic [7:0] saved_ff;
	logic usr_wr_ff;
	logic poll_due;
	logic timeout;
	logic rsp_ok;
	logic [4:0] ini_k;
	logic [4:0] nxt_step;
	csp_pkg::csp_op_type ini_op;
	logic [15:0] ini_fid;

	assign lnk.link_up = link_up_ff;
	assign lnk.cmd_valid = (state_ff == csp_pkg::ST_SEND);
	assign lnk.cmd_op = op_ff;
	assign lnk.cmd_fid = fid_ff;
	assign lnk.cmd_ofs = ofs_ff;
	assign lnk.cmd_data = dat_ff;
	assign loc_o = loc_ff;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	// One counter serves both the idle poll and the answer deadline.
	assign poll_due = call_active_i && (tmr_ff == POLL_LAST);
	assign timeout = (state_ff == csp_pkg::ST_WAIT) &&
		!lnk.rsp_valid && (tmr_ff == RSP_LAST);
	assign rsp_ok = (lnk.rsp_sw == csp_pkg::SW_OK);
	assign usr_ready_o = (state_ff == csp_pkg::ST_SESS) && !poll_due &&
		!sess_end_i;

	// Idle time restarts at every command and every answer.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			tmr_ff <= '0;
		else if (state_ff == csp_pkg::ST_SEND || lnk.rsp_valid)
			tmr_ff <= '0;
		else if (tmr_ff != POLL_LAST)
			tmr_ff <= `CSP_TMR_W'(tmr_ff + 1'b1);
	end

	// ------------------------------------------------------------
	// Initialization step table
	// ------------------------------------------------------------
	// The table names the command of the step after the current one.
	// Steps 5 and up alternate select and read over files 1 to 11.
	assign nxt_step = 5'(step_ff + 5'h01);

	always_comb begin
		ini_k = 5'(nxt_step - 5'h05);
		ini_op = ini_k[0] ? csp_pkg::OP_READ : csp_pkg::OP_SELECT;
		ini_fid = {`CSP_EF_HI, 4'h0, 4'(ini_k[4:1] + 4'h1)};
		case (nxt_step)
			5'h00: begin
				ini_op = csp_pkg::OP_SELECT;
				ini_fid = {`CSP_EF_HI, 4'h0, `CSP_LP_IDX};
			end
			5'h01: begin
				ini_op = csp_pkg::OP_READ;
				ini_fid = 16'h0000;
			end
			5'h02: begin
				ini_op = csp_pkg::OP_SELECT;
				ini_fid = `CSP_DIR_FID;
			end
			5'h03: begin
				ini_op = csp_pkg::OP_SELECT;
				ini_fid = {`CSP_EF_HI, 4'h0, `CSP_IDENT_IDX};
			end
			5'h04: begin
				ini_op = csp_pkg::OP_VERIFY;
				ini_fid = code_i;
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	// A lost answer means a lost link: the running procedure is
	// abandoned whole and the session ends.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_ff <= csp_pkg::ST_OFF;
			job_ff <= csp_pkg::JB_INIT;
			step_ff <= 5'h00;
			link_up_ff <= 1'b0;
			op_ff <= csp_pkg::OP_SELECT;
			fid_ff <= 16'h0000;
			ofs_ff <= 8'h00;
			dat_ff <= 8'h00;
			loc_ff <= 8'h00;
			saved_ff <= 8'h00;
			usr_wr_ff <= 1'b0;
			usr_done_o <= 1'b0;
			usr_ok_o <= 1'b0;
			usr_data_o <= 8'h00;
			sess_active_o <= 1'b0;
			init_fail_o <= 1'b0;
			ident_invalid_o <= 1'b0;
			call_drop_o <= 1'b0;
			lang_o <= `CSP_LANG_DEFAULT;
		end else begin
			usr_done_o <= 1'b0;
			init_fail_o <= 1'b0;
			ident_invalid_o <= 1'b0;
			call_drop_o <= 1'b0;
			// The local copy may change only while a session is open.
			if (loc_we_i && sess_active_o)
				loc_ff <= loc_i;
			case (state_ff)
				csp_pkg::ST_OFF: begin
					if (sess_start_i) begin
						link_up_ff <= 1'b1;
						job_ff <= csp_pkg::JB_INIT;
						step_ff <= 5'h00;
						op_ff <= csp_pkg::OP_SELECT;
						fid_ff <= {`CSP_EF_HI, 4'h0, `CSP_LP_IDX};
						ofs_ff <= 8'h00;
						state_ff <= csp_pkg::ST_SEND;
					end
				end
				csp_pkg::ST_SEND: state_ff <= csp_pkg::ST_WAIT;
				// Ending beats polling, which beats a user request.
				csp_pkg::ST_SESS: begin
					step_ff <= 5'h00;
					if (sess_end_i) begin
						job_ff <= csp_pkg::JB_TERM;
						op_ff <= csp_pkg::OP_SELECT;
						fid_ff <= {`CSP_EF_HI, 4'h0, `CSP_LOC_IDX};
						if (loc_ff == saved_ff) begin
							link_up_ff <= 1'b0;
							loc_ff <= 8'h00;
							sess_active_o <= 1'b0;
							state_ff <= csp_pkg::ST_OFF;
						end else begin
							state_ff <= csp_pkg::ST_SEND;
						end
					end else if (poll_due) begin
						job_ff <= csp_pkg::JB_POLL;
						op_ff <= csp_pkg::OP_STATUS;
						state_ff <= csp_pkg::ST_SEND;
					end else if (usr_valid_i) begin
						job_ff <= csp_pkg::JB_USR;
						usr_wr_ff <= usr_write_i;
						op_ff <= csp_pkg::OP_SELECT;
						fid_ff <= usr_fid_i;
						ofs_ff <= usr_ofs_i;
						dat_ff <= usr_data_i;
						state_ff <= csp_pkg::ST_SEND;
					end
				end
				csp_pkg::ST_WAIT: begin
					if (timeout) begin
						state_ff <= csp_pkg::ST_OFF;
						link_up_ff <= 1'b0;
						sess_active_o <= 1'b0;
						call_drop_o <= (job_ff == csp_pkg::JB_POLL);
						init_fail_o <= (job_ff == csp_pkg::JB_INIT);
						usr_done_o <= (job_ff == csp_pkg::JB_USR);
						usr_ok_o <= 1'b0;
					end else if (lnk.rsp_valid) begin
						case (job_ff)
							csp_pkg::JB_INIT: begin
								if (step_ff == 5'h01) begin
									lang_o <= (lnk.rsp_data[7:0] == `CSP_LANG_NONE ||
										!rsp_ok) ? `CSP_LANG_DEFAULT :
										lnk.rsp_data[7:0];
								end
								if (step_ff == 5'h14) begin
									loc_ff <= lnk.rsp_data[7:0];
									saved_ff <= lnk.rsp_data[7:0];
								end
								if (step_ff == 5'h03 && lnk.rsp_data[0]) begin
									ident_invalid_o <= 1'b1;
									init_fail_o <= 1'b1;
									link_up_ff <= 1'b0;
									state_ff <= csp_pkg::ST_OFF;
								end else if (step_ff > 5'h01 && !rsp_ok) begin
									init_fail_o <= 1'b1;
									link_up_ff <= 1'b0;
									state_ff <= csp_pkg::ST_OFF;
								end else if (step_ff == `CSP_INIT_LAST) begin
									sess_active_o <= 1'b1;
									state_ff <= csp_pkg::ST_SESS;
								end else begin
									step_ff <= nxt_step;
									op_ff <= ini_op;
									fid_ff <= ini_fid;
									state_ff <= csp_pkg::ST_SEND;
								end
							end
							csp_pkg::JB_USR: begin
								if (step_ff == 5'h00 && rsp_ok) begin
									op_ff <= usr_wr_ff ? csp_pkg::OP_UPDATE :
										csp_pkg::OP_READ;
									step_ff <= 5'h01;
									state_ff <= csp_pkg::ST_SEND;
								end else begin
									usr_done_o <= 1'b1;
									usr_ok_o <= rsp_ok;
									usr_data_o <= lnk.rsp_data[7:0];
									state_ff <= csp_pkg::ST_SESS;
								end
							end
							// Another directory means another card was put in.
							csp_pkg::JB_POLL: begin
								if (!rsp_ok || lnk.rsp_data != `CSP_DIR_FID) begin
									call_drop_o <= 1'b1;
									link_up_ff <= 1'b0;
									sess_active_o <= 1'b0;
									state_ff <= csp_pkg::ST_OFF;
								end else begin
									state_ff <= csp_pkg::ST_SESS;
								end
							end
							default: begin
								if (step_ff == 5'h00 && rsp_ok) begin
									op_ff <= csp_pkg::OP_UPDATE;
									dat_ff <= loc_ff;
									ofs_ff <= 8'h00;
									step_ff <= 5'h01;
									state_ff <= csp_pkg::ST_SEND;
								end else begin
									link_up_ff <= 1'b0;
									loc_ff <= 8'h00;
									sess_active_o <= 1'b0;
									state_ff <= csp_pkg::ST_OFF;
								end
							end
						endcase
					end
				end
				default: state_ff <= csp_pkg::ST_OFF;
			endcase
		end
	end

endmodule

// ---- tb/csp_props.sv ----
`include "csp_params.svh"

// Watches the link between the two ends; sees only the wire signals.
module csp_props (
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic link_up,
	input wire logic cmd_valid,
	input wire csp_pkg::csp_op_type cmd_op,
	input wire logic [15:0] cmd_fid,
	input wire logic [7:0] cmd_ofs,
	input wire logic [7:0] cmd_data,
	input wire logic rsp_valid,
	input wire csp_pkg::csp_sw_type rsp_sw,
	input wire logic [15:0] rsp_data
);
	// ------------------------------------------------------------
	// Helper state
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	logic pend_ff, ef_ff, ok_ff;
	logic [1:0] bad_ff;
	logic [15:0] fid_ff;
	logic [15:0] dir_ff;
	csp_pkg::csp_op_type op_ff;
	csp_pkg::csp_op_type op_now;
	logic [15:0] fid_now;
	logic rsp_ok;
	logic rsp_ver;
	logic locked;

	// The answer may come while the command is still shown.
	assign op_now = cmd_valid ? cmd_op : op_ff;
	assign fid_now = cmd_valid ? cmd_fid : fid_ff;
	assign rsp_ok = rsp_valid && rsp_sw == csp_pkg::SW_OK;
	assign rsp_ver = rsp_valid && op_now == csp_pkg::OP_VERIFY;
	assign locked = fid_now[15:8] == `CSP_EF_HI &&
		fid_now[3:0] > `CSP_FREE_LAST && !ok_ff;

	// Outstanding command and its op and file.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_ff <= 1'b0;
			op_ff <= csp_pkg::OP_SELECT;
			fid_ff <= 16'h0000;
		end else begin
			pend_ff <= cmd_valid || (pend_ff && !rsp_valid);
			if (cmd_valid) begin
				op_ff <= cmd_op;
				fid_ff <= cmd_fid;
			end
		end
	end

	// Selection and verification history; the flags clear when the link drops, dir_ff is kept.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ef_ff <= 1'b0;
			ok_ff <= 1'b0;
			dir_ff <= `CSP_DIR_FID;
		end else if (!link_up) begin
			ef_ff <= 1'b0;
			ok_ff <= 1'b0;
		end else if (rsp_ok && op_now == csp_pkg::OP_SELECT) begin
			ef_ff <= fid_now[15:8] == `CSP_EF_HI;
			if (fid_now[15:8] != `CSP_EF_HI)
				dir_ff <= fid_now;
		end else if (rsp_ver) begin
			ok_ff <= rsp_sw == csp_pkg::SW_OK;
		end
	end

	// Wrong codes count across sessions; only reset or a right code clears it.
	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i)
			bad_ff <= 2'h0;
		else if (rsp_ver && rsp_sw == csp_pkg::SW_OK)
			bad_ff <= 2'h0;
		else if (rsp_ver && bad_ff != 2'h3)
			bad_ff <= bad_ff + 2'h1;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_answer_needs_cmd: assert property (
		rsp_valid |-> pend_ff || cmd_valid)
		else $error("answer without a command");
	a_cmd_needs_link: assert property (
		cmd_valid |-> link_up)
		else $error("command while link is down");
	a_file_before_rw: assert property (
		cmd_valid && (cmd_op == csp_pkg::OP_READ ||
		cmd_op == csp_pkg::OP_UPDATE) |-> ef_ff)
		else $error("read or update with no file selected");
	a_app_dir_id: assert property (
		cmd_valid && cmd_op == csp_pkg::OP_SELECT &&
		cmd_fid[15:8] != `CSP_EF_HI |-> cmd_fid == `CSP_DIR_FID)
		else $error("directory selected by a wrong identifier");
	a_status_names_dir: assert property (
		rsp_ok && op_now == csp_pkg::OP_STATUS |-> rsp_data == dir_ff)
		else $error("status answer names another directory");
	a_locked_read: assert property (
		rsp_valid && op_now == csp_pkg::OP_READ && locked |->
		rsp_sw != csp_pkg::SW_OK)
		else $error("protected read answered without access");
	a_locked_update: assert property (
		rsp_valid && op_now == csp_pkg::OP_UPDATE && locked |->
		rsp_sw != csp_pkg::SW_OK)
		else $error("protected update accepted without access");
	a_third_blocks: assert property (
		rsp_ver && bad_ff == 2'h3 |-> rsp_sw == csp_pkg::SW_BLOCKED)
		else $error("code not blocked after three wrong tries");
	c_status: cover property (rsp_ok && op_now == csp_pkg::OP_STATUS);
endmodule

// ---- tb/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Clock, reset and instances
	// ------------------------------------------------------------
	logic mclk_i = 1'b0, sys_rst_i = 1'b1;
	logic sess_start_i = 0, sess_end_i = 0, call_active_i = 0;
	logic usr_valid_i = 0, usr_write_i = 0, loc_we_i = 0;
	logic [15:0] code_i = 16'h0000, usr_fid_i = 16'h0000;
	logic [7:0] usr_ofs_i = 8'h00, usr_data_i = 8'h00, loc_i = 8'h00;
	logic usr_ready_o, usr_done_o, usr_ok_o, sess_active_o;
	logic init_fail_o, ident_invalid_o, call_drop_o;
	logic code_blocked_o, access_granted_o;
	logic [7:0] usr_data_o, lang_o, loc_o;
	logic [15:0] cur_dir_o;
	int n_fail = 0, num_checks = 0;
	csp_link_if lnk();

	// Short poll and answer limits keep the run brief.
	always #2.5 mclk_i = ~mclk_i;

	csp_card csp_card_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.lnk(lnk.card), .code_blocked_o(code_blocked_o),
		.access_granted_o(access_granted_o), .cur_dir_o(cur_dir_o));
	csp_term #(.POLL_CYC(200), .RSP_CYC(100)) csp_term_inst (
		.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .lnk(lnk.term),
		.sess_start_i(sess_start_i), .sess_end_i(sess_end_i),
		.call_active_i(call_active_i), .code_i(code_i),
		.usr_valid_i(usr_valid_i), .usr_write_i(usr_write_i),
		.usr_fid_i(usr_fid_i), .usr_ofs_i(usr_ofs_i),
		.usr_data_i(usr_data_i), .loc_we_i(loc_we_i), .loc_i(loc_i),
		.usr_ready_o(usr_ready_o), .usr_done_o(usr_done_o),
		.usr_ok_o(usr_ok_o), .usr_data_o(usr_data_o),
		.sess_active_o(sess_active_o), .init_fail_o(init_fail_o),
		.ident_invalid_o(ident_invalid_o), .call_drop_o(call_drop_o),
		.lang_o(lang_o), .loc_o(loc_o));
	csp_props csp_props_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
		.link_up(lnk.link_up), .cmd_valid(lnk.cmd_valid),
		.cmd_op(lnk.cmd_op), .cmd_fid(lnk.cmd_fid),
		.cmd_ofs(lnk.cmd_ofs), .cmd_data(lnk.cmd_data),
		.rsp_valid(lnk.rsp_valid), .rsp_sw(lnk.rsp_sw),
		.rsp_data(lnk.rsp_data));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task complete_run;
		if (n_fail == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// A hung wait counts as a failure and ends the run at once.
	task give_up;
		n_fail++;
		complete_run();
	endtask

	task start_sess(input logic [15:0] code);
		@(negedge mclk_i);
		code_i = code;
		sess_start_i = 1'b1;
		@(negedge mclk_i);
		sess_start_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		for (int i = 0; !(sess_active_o === 1'b1 ||
			init_fail_o === 1'b1); i++) begin
			if (i > 5000)
				give_up();
			@(negedge mclk_i);
		end
	endtask

	// Request is held until ready is seen at a rising edge.
	task usr_op(input logic wr, input logic [7:0] ofs,
		input logic [7:0] dat);
		@(negedge mclk_i);
		usr_valid_i = 1'b1;
		usr_write_i = wr;
		usr_fid_i = 16'h6F05;
		usr_ofs_i = ofs;
		usr_data_i = dat;
		for (int i = 0; usr_ready_o !== 1'b1; i++) begin
			if (i > 2000)
				give_up();
			@(negedge mclk_i);
		end
		@(negedge mclk_i);
		usr_valid_i = 1'b0;
		for (int i = 0; usr_done_o !== 1'b1; i++) begin
			if (i > 2000)
				give_up();
			@(negedge mclk_i);
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task sc_init_ok;
		start_sess(16'h1234);
		check(sess_active_o, 1'b1);
		check(init_fail_o, 1'b0);
		check(ident_invalid_o, 1'b0);
		check(access_granted_o, 1'b1);
		check(cur_dir_o, 16'h7F90);
		check(lang_o, 8'h01);
	endtask

	// Two neighbouring bytes: writing the second must not change the first.
	task sc_rw;
		usr_op(1'b1, 8'h02, 8'hA5);
		check(usr_ok_o, 1'b1);
		usr_op(1'b1, 8'h03, 8'h5A);
		check(usr_ok_o, 1'b1);
		usr_op(1'b0, 8'h02, 8'h00);
		check(usr_data_o, 8'hA5);
		usr_op(1'b0, 8'h03, 8'h00);
		check(usr_data_o, 8'h5A);
	endtask

	task sc_poll;
		int seen;
		seen = 0;
		@(negedge mclk_i);
		call_active_i = 1'b1;
		for (int i = 0; i < 260 && seen == 0; i++) begin
			@(negedge mclk_i);
			if (lnk.cmd_valid === 1'b1 &&
				lnk.cmd_op === csp_pkg::OP_STATUS)
				seen = 1;
		end
		check(seen, 1);
		repeat (400) @(negedge mclk_i);
		check(call_drop_o, 1'b0);
		check(sess_active_o, 1'b1);
		call_active_i = 1'b0;
	endtask

	// With a fresh location the copy is written back; without, skipped.
	task sc_end(input logic we);
		@(negedge mclk_i);
		loc_we_i = we;
		loc_i = 8'h3C;
		@(negedge mclk_i);
		loc_we_i = 1'b0;
		check(loc_o, 8'h3C);
		sess_end_i = 1'b1;
		for (int i = 0; sess_active_o !== 1'b0; i++) begin
			if (i > 5000)
				give_up();
			@(negedge mclk_i);
		end
		sess_end_i = 1'b0;
		check(sess_active_o, 1'b0);
		check(loc_o, 8'h00);
	endtask

	// Three wrong codes in a row, then even the right one is refused.
	task sc_block;
		for (int i = 0; i < 3; i++) begin
			start_sess(16'h0BAD);
			check(init_fail_o, 1'b1);
		end
		check(code_blocked_o, 1'b1);
		check(access_granted_o, 1'b0);
		start_sess(16'h1234);
		check(init_fail_o, 1'b1);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(negedge mclk_i);
		sys_rst_i = 1'b0;
		check(sess_active_o, 1'b0);
		sc_init_ok();
		sc_rw();
		sc_poll();
		sc_end(1'b1);
		start_sess(16'h1234);
		check(sess_active_o, 1'b1);
		sc_end(1'b0);
		sc_block();
		complete_run();
	end
endmodule
